// [uhis_axil_slave.sv]
module uhis_axil_slave
  import uhis_pkg::*;
(
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // write address and data
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // read address and data
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // register side
  input wire logic [31:0] rd_word,
  output logic wr_valid,
  output uhis_wr_t wr
);

  uhis_ch_t wst_reg, wst_next, rst_reg, rst_next;
  logic aw_have_reg, aw_have_next, w_have_reg, w_have_next;
  logic [7:0] awaddr_reg, awaddr_next;
  logic [31:0] wdata_reg, wdata_next;
  logic [3:0] wstrb_reg, wstrb_next;
  logic awready_reg, awready_next, wready_reg, wready_next;
  logic bvalid_reg, bvalid_next, arready_reg, arready_next;
  logic rvalid_reg, rvalid_next, wr_valid_reg, wr_valid_next;
  logic [1:0] bresp_reg, bresp_next, rresp_reg, rresp_next;
  logic [31:0] rdata_reg, rdata_next;
  uhis_wr_t wr_reg, wr_next;

  always_comb begin
    wst_next = wst_reg;
    aw_have_next = aw_have_reg;
    w_have_next = w_have_reg;
    awaddr_next = awaddr_reg;
    wdata_next = wdata_reg;
    wstrb_next = wstrb_reg;
    bvalid_next = bvalid_reg;
    bresp_next = bresp_reg;
    wr_valid_next = 1'b0;
    wr_next = wr_reg;
    // address and data may arrive in either order
    if (s_axi_awvalid && awready_reg) begin
      aw_have_next = 1'b1;
      awaddr_next = s_axi_awaddr;
    end
    if (s_axi_wvalid && wready_reg) begin
      w_have_next = 1'b1;
      wdata_next = s_axi_wdata;
      wstrb_next = s_axi_wstrb;
    end
    unique case (wst_reg)
      CH_IDLE: begin
        if (aw_have_next && w_have_next) begin
          wst_next = CH_RESP;
          bvalid_next = 1'b1;
          bresp_next = uhis_addr_ok(awaddr_next) ? RESP_OKAY : RESP_SLVERR;
          wr_valid_next = 1'b1;
          wr_next = '{addr: awaddr_next, data: wdata_next, strb: wstrb_next};
          aw_have_next = 1'b0;
          w_have_next = 1'b0;
        end
      end
      CH_RESP: begin
        if (s_axi_bready) begin
          wst_next = CH_IDLE;
          bvalid_next = 1'b0;
        end
      end
    endcase
    awready_next = (wst_next == CH_IDLE) && !aw_have_next;
    wready_next = (wst_next == CH_IDLE) && !w_have_next;
  end

  always_comb begin
    rst_next = rst_reg;
    rvalid_next = rvalid_reg;
    rdata_next = rdata_reg;
    rresp_next = rresp_reg;
    unique case (rst_reg)
      CH_IDLE: begin
        if (s_axi_arvalid && arready_reg) begin
          rst_next = CH_RESP;
          rvalid_next = 1'b1;
          rdata_next = uhis_addr_ok(s_axi_araddr) ? rd_word : 32'h0;
          rresp_next = uhis_addr_ok(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
        end
      end
      CH_RESP: begin
        if (s_axi_rready) begin
          rst_next = CH_IDLE;
          rvalid_next = 1'b0;
        end
      end
    endcase
    arready_next = (rst_next == CH_IDLE);
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wst_reg <= CH_IDLE;
      rst_reg <= CH_IDLE;
      aw_have_reg <= 1'b0;
      w_have_reg <= 1'b0;
      awaddr_reg <= 8'h0;
      wdata_reg <= 32'h0;
      wstrb_reg <= 4'h0;
      awready_reg <= 1'b0;
      wready_reg <= 1'b0;
      bvalid_reg <= 1'b0;
      bresp_reg <= RESP_OKAY;
      arready_reg <= 1'b0;
      rvalid_reg <= 1'b0;
      rdata_reg <= 32'h0;
      rresp_reg <= RESP_OKAY;
      wr_valid_reg <= 1'b0;
      wr_reg <= '0;
    end else begin
      wst_reg <= wst_next;
      rst_reg <= rst_next;
      aw_have_reg <= aw_have_next;
      w_have_reg <= w_have_next;
      awaddr_reg <= awaddr_next;
      wdata_reg <= wdata_next;
      wstrb_reg <= wstrb_next;
      awready_reg <= awready_next;
      wready_reg <= wready_next;
      bvalid_reg <= bvalid_next;
      bresp_reg <= bresp_next;
      arready_reg <= arready_next;
      rvalid_reg <= rvalid_next;
      rdata_reg <= rdata_next;
      rresp_reg <= rresp_next;
      wr_valid_reg <= wr_valid_next;
      wr_reg <= wr_next;
    end
  end

  assign s_axi_awready = awready_reg;
  assign s_axi_wready = wready_reg;
  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp = bresp_reg;
  assign s_axi_arready = arready_reg;
  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rdata = rdata_reg;
  assign s_axi_rresp = rresp_reg;
  assign wr_valid = wr_valid_reg;
  assign wr = wr_reg;

endmodule

// [uhis_bench.sv]
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin \
  bad_count++; $display("unexpected %s exp %h got %h", nm, e, g); end end

module uhis_bench
  import uhis_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;

  logic aclk = 1'b0;
  logic aresetn;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd_data;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, overrun_count, rd_resp;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic s_axi_rvalid, s_axi_rready;
  uhis_evt_t evt;
  logic [15:0] frame_number;
  logic ownership_change_request_a, bus_resume_state, resume_line;
  logic irq, system_management_interrupt, sof_token;
  logic processing_halt, done_head_hold;
  int bad_count = 0;
  int n_checks = 0;

  always #20 aclk = ~aclk;

  uhis_top dut_u (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .evt, .frame_number,
    .ownership_change_request_a, .bus_resume_state, .resume_line, .irq,
    .system_management_interrupt, .sof_token, .processing_halt,
    .done_head_hold, .overrun_count
  );

  task automatic final_report;
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic timeout;
    bad_count++;
    $display("unexpected handshake exp done got timeout");
    final_report();
  endtask

  // every bus task starts just after a rising edge and ends on one
  task automatic axi_write(input logic [7:0] a, input logic [31:0] d,
                           input logic [3:0] s, input logic [1:0] er);
    int n;
    logic done;
    n = 0;
    done = 1'b0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    while (!done) begin
      @(posedge aclk);
      n++;
      if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid === 1'b1) begin
        done = 1'b1;
        `CHK("bresp", er, s_axi_bresp)
      end
      if (n > 50) timeout();
    end
  endtask

  task automatic axi_read(input logic [7:0] a);
    int n;
    logic done;
    n = 0;
    done = 1'b0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    while (!done) begin
      @(posedge aclk);
      n++;
      if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid === 1'b1) begin
        done = 1'b1;
        rd_data = s_axi_rdata;
        rd_resp = s_axi_rresp;
      end
      if (n > 50) timeout();
    end
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [31:0] e,
                       input string nm);
    axi_read(a);
    `CHK(nm, e, rd_data)
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    axi_write(a, d, 4'hf, RESP_OKAY);
  endtask

  // sampled by the design at the first edge; results seen after it
  task automatic pulse(input int i);
    evt <= uhis_evt_t'(6'h01 << i);
    @(posedge aclk);
    evt <= '0;
    #1;
  endtask

  task automatic settle(input int n);
    repeat (n) @(posedge aclk);
    #1;
  endtask

  initial begin
    aresetn = 1'b0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_arvalid} = '0;
    // response readies stay high so back-to-back calls never clash
    s_axi_bready = 1'b1;
    s_axi_rready = 1'b1;
    evt = '0;
    frame_number = 16'h0000;
    ownership_change_request_a = 1'b0;
    bus_resume_state = 1'b0;
    resume_line = 1'b0;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rdchk(OFS_STATUS, 32'h0, "status");
    rdchk(OFS_ENABLE, 32'h0, "enable");
    `CHK("irq", 1'b0, irq)
    `CHK("overrun_count", 2'h0, overrun_count)
    axi_write(8'h08, 32'hffff_ffff, 4'hf, RESP_SLVERR);
    axi_read(8'h0c);
    `CHK("rresp", RESP_SLVERR, rd_resp)
    `CHK("rdata", 32'h0, rd_data)
    $display("test reset and decode done");
    // enables only ever gain bits; reserved positions stay zero
    axi_write(OFS_ENABLE, 32'h0000_0008, 4'h0, RESP_OKAY);
    rdchk(OFS_ENABLE, 32'h0, "enable");
    wr(OFS_ENABLE, 32'h3fff_ff81);
    rdchk(OFS_ENABLE, 32'h1, "enable");
    wr(OFS_ENABLE, 32'h0);
    wr(OFS_ENABLE, 32'h8000_0000);
    rdchk(OFS_ENABLE, 32'h8000_0001, "enable");
    $display("test enable done");
    pulse(4);
    `CHK("sof_token", 1'b1, sof_token)
    settle(2);
    `CHK("irq", 1'b0, irq)
    pulse(0);
    settle(2);
    `CHK("irq", 1'b1, irq)
    rdchk(OFS_STATUS, 32'h5, "status");
    wr(OFS_STATUS, 32'h4);
    rdchk(OFS_STATUS, 32'h1, "status");
    wr(OFS_STATUS, 32'h0);
    settle(20);
    rdchk(OFS_STATUS, 32'h1, "status");
    `CHK("irq", 1'b1, irq)
    `CHK("overrun_count", 2'h1, overrun_count)
    wr(OFS_STATUS, 32'h1);
    settle(2);
    `CHK("irq", 1'b0, irq)
    $display("test flags done");
    // count keeps going while the flag is already set
    for (int j = 0; j < 3; j++) begin
      pulse(0);
      `CHK("overrun_count", 2'(2 + j), overrun_count)
    end
    rdchk(OFS_STATUS, 32'h1, "status");
    wr(OFS_STATUS, 32'h1);
    $display("test overrun done");
    pulse(1);
    pulse(2);
    pulse(5);
    `CHK("done_head_hold", 1'b1, done_head_hold)
    `CHK("processing_halt", 1'b1, processing_halt)
    rdchk(OFS_STATUS, 32'h52, "status");
    // done head taken as saved before its flag is cleared
    wr(OFS_STATUS, 32'h42);
    settle(1);
    `CHK("done_head_hold", 1'b0, done_head_hold)
    `CHK("processing_halt", 1'b1, processing_halt)
    // reset clears the error flag, so the clear write that follows finds it zero
    aresetn <= 1'b0;
    settle(2);
    aresetn <= 1'b1;
    settle(1);
    wr(OFS_STATUS, 32'h10);
    `CHK("processing_halt", 1'b0, processing_halt)
    rdchk(OFS_ENABLE, 32'h0, "enable");
    $display("test events done");
    wr(OFS_ENABLE, 32'hc000_0000);
    ownership_change_request_a <= 1'b1;
    settle(3);
    `CHK("mgmt_irq", 1'b1, system_management_interrupt)
    `CHK("irq", 1'b1, irq)
    rdchk(OFS_STATUS, 32'h4000_0000, "status");
    wr(OFS_STATUS, 32'h4000_0000);
    settle(2);
    `CHK("mgmt_irq", 1'b0, system_management_interrupt)
    $display("test ownership done");
    // toggle held back until the frame copy completes
    frame_number <= 16'h8000;
    settle(3);
    rdchk(OFS_STATUS, 32'h0, "status");
    pulse(3);
    rdchk(OFS_STATUS, 32'h20, "status");
    wr(OFS_STATUS, 32'h20);
    frame_number <= 16'h0000;
    settle(2);
    pulse(3);
    rdchk(OFS_STATUS, 32'h20, "status");
    wr(OFS_STATUS, 32'h20);
    $display("test frame overflow done");
    bus_resume_state <= 1'b1;
    resume_line <= 1'b1;
    settle(6);
    rdchk(OFS_STATUS, 32'h0, "status");
    bus_resume_state <= 1'b0;
    resume_line <= 1'b0;
    settle(4);
    resume_line <= 1'b1;
    settle(6);
    rdchk(OFS_STATUS, 32'h8, "status");
    $display("test resume done");
    final_report();
  end
endmodule

// [uhis_pkg.sv]
package uhis_pkg;

  // register byte offsets on the register bus
  localparam logic [7:0] OFS_STATUS = 8'h00;
  localparam logic [7:0] OFS_ENABLE = 8'h04;

  // flag and enable bit positions, and the frame number bit watched for overflow
  localparam int B_SO = 0;
  localparam int B_WDH = 1;
  localparam int B_FRM_START = 2;
  localparam int B_RD = 3;
  localparam int B_ERR = 4;
  localparam int B_FN_OVF = 5;
  localparam int B_HUB_CHG = 6;
  localparam int B_OWN_CHG = 30;
  localparam int B_GATE = 31;
  localparam int B_FN_MSB = 15;

  // implemented bits; everything else reads zero
  localparam logic [31:0] STATUS_MASK = 32'h4000_007f;
  localparam logic [31:0] ENABLE_MASK = 32'hc000_007f;

  // values after reset
  localparam logic [31:0] STATUS_RESET = 32'h0000_0000;
  localparam logic [31:0] ENABLE_RESET = 32'h0000_0000;
  localparam logic [1:0] OVC_RESET = 2'h0;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic [7:0] addr;
    logic [31:0] data;
    logic [3:0] strb;
  } uhis_wr_t;

  // single-cycle event strobes from the rest of the controller
  typedef struct packed {
    logic root_hub_change;
    logic frame_start;
    logic fn_copy_done;
    logic system_error;
    logic done_head_written;
    logic overrun;
  } uhis_evt_t;

  typedef enum logic [1:0] {
    CH_IDLE = 2'b01,
    CH_RESP = 2'b10
  } uhis_ch_t;

  function automatic logic uhis_addr_ok(input logic [7:0] a);
    return (a == OFS_STATUS) || (a == OFS_ENABLE);
  endfunction

  function automatic logic [31:0] uhis_strb_mask(input logic [3:0] s);
    logic [31:0] m;
    m = 32'h0;
    for (int i = 0; i < 4; i++) begin
      m[i*8 +: 8] = {8{s[i]}};
    end
    return m;
  endfunction

endpackage

// [uhis_sync_rise.sv]
module uhis_sync_rise
  import uhis_pkg::*;
(
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // pin side
  input wire logic async_in,
  // clocked side
  output logic rise
);

  logic meta_reg, meta_next;
  logic sync_reg, sync_next;
  logic prev_reg, prev_next;

  // only the second stage and later feed the edge detector
  always_comb begin
    meta_next = async_in;
    sync_next = meta_reg;
    prev_next = sync_reg;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      meta_reg <= 1'b0;
      sync_reg <= 1'b0;
      prev_reg <= 1'b0;
    end else begin
      meta_reg <= meta_next;
      sync_reg <= sync_next;
      prev_reg <= prev_next;
    end
  end

  assign rise = sync_reg & ~prev_reg;

endmodule

// [uhis_top.sv]
// Operation
// - each monitored event sets its status flag, which stays set.
// - interrupt requested only if flag, its enable and master gate set.
// - writing one clears a status flag; zero leaves it untouched.
// - hardware never clears a status flag itself.
// - ownership change flag sets when the ownership request bit rises.
// - unmasked ownership change raises the management interrupt the cycle after its flag sets.
// - without management interrupt output the ownership flag stays zero.
// - root hub change flag sets on any root hub or port status change.
// - frame overflow flag sets when frame bit 15 toggles, after copy.
// - unrecoverable error flag sets on system error; processing halts.
// - resume flag sets on device resume start, not software resume.
// - frame start flag sets each frame, with a frame start token.
// - done head flag sets after writeback; no writeback while set.
// - overrun flag sets on schedule overrun; overrun count increments.
// - two-bit overrun count starts at zero, counts every overrun, wraps.
// - writing one sets an enable bit; zero leaves it; reads current.
// - each enable bit except the master gate (bit 31) gates only its matching status flag.
//
// The AXI4-Lite register port and the placing of the registers were chosen for this implementation.
module uhis_top
  import uhis_pkg::*;
#(
  parameter bit MGMT_IRQ_PRESENT = 1'b1
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // register bus
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // controller events and state
  input wire uhis_evt_t evt,
  input wire logic [15:0] frame_number,
  input wire logic ownership_change_request_a,
  input wire logic bus_resume_state,
  // resume signalling seen on the bus pins
  input wire logic resume_line,
  // requests and controls out
  output logic irq,
  output logic system_management_interrupt,
  output logic sof_token,
  output logic processing_halt,
  output logic done_head_hold,
  output logic [1:0] overrun_count
);

  uhis_wr_t wr;
  logic wr_valid;
  logic [31:0] rd_word;
  logic res_rise;

  logic [31:0] status_reg, status_next;
  logic [31:0] enable_reg, enable_next;
  logic [31:0] set_vec, clr_vec, en_set_vec;
  logic irq_reg, irq_next;
  logic mgmt_reg, mgmt_next;
  logic sof_reg, sof_next;
  logic [1:0] ovc_reg, ovc_next;
  logic ocr_prev_reg, ocr_prev_next;
  logic fn_msb_reg, fn_msb_next;
  logic fn_pend_reg, fn_pend_next;
  logic ocr_rise, fn_toggle;

  uhis_axil_slave u_bus (
    .aclk(aclk),
    .aresetn(aresetn),
    .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready),
    .rd_word(rd_word),
    .wr_valid(wr_valid),
    .wr(wr)
  );

  // bus resume line is asynchronous to aclk
  uhis_sync_rise u_resume (
    .aclk(aclk),
    .aresetn(aresetn),
    .async_in(resume_line),
    .rise(res_rise)
  );

  assign ocr_rise = ownership_change_request_a & ~ocr_prev_reg;
  assign fn_toggle = frame_number[B_FN_MSB] ^ fn_msb_reg;

  always_comb begin
    set_vec = 32'h0;
    set_vec[B_OWN_CHG] = MGMT_IRQ_PRESENT && ocr_rise;
    set_vec[B_HUB_CHG] = evt.root_hub_change;
    // toggle waits until the shared copy has been written
    set_vec[B_FN_OVF] = evt.fn_copy_done && (fn_pend_reg || fn_toggle);
    set_vec[B_ERR] = evt.system_error;
    // software entering resume is not a device resume
    set_vec[B_RD] = res_rise && !bus_resume_state;
    set_vec[B_FRM_START] = evt.frame_start;
    set_vec[B_WDH] = evt.done_head_written;
    set_vec[B_SO] = evt.overrun;
  end

  always_comb begin
    clr_vec = 32'h0;
    en_set_vec = 32'h0;
    if (wr_valid && wr.addr == OFS_STATUS) begin
      clr_vec = wr.data & uhis_strb_mask(wr.strb);
    end
    if (wr_valid && wr.addr == OFS_ENABLE) begin
      en_set_vec = wr.data & uhis_strb_mask(wr.strb);
    end
    // a set in the same cycle as its clear wins, so no event is lost
    status_next = ((status_reg & ~clr_vec) | set_vec) & STATUS_MASK;
    if (!MGMT_IRQ_PRESENT) begin
      status_next[B_OWN_CHG] = 1'b0;
    end
    // enables only ever set; there is no disable path here
    enable_next = (enable_reg | en_set_vec) & ENABLE_MASK;
  end

  always_comb begin
    irq_next = enable_reg[B_GATE]
      && |(status_reg[B_OWN_CHG:0] & enable_reg[B_OWN_CHG:0]);
    mgmt_next = status_reg[B_OWN_CHG] && enable_reg[B_OWN_CHG];
    sof_next = evt.frame_start;
    ovc_next = ovc_reg;
    if (evt.overrun) begin
      ovc_next = ovc_reg + 2'h1;
    end
    ocr_prev_next = ownership_change_request_a;
    fn_msb_next = frame_number[B_FN_MSB];
    fn_pend_next = (fn_pend_reg || fn_toggle) && !evt.fn_copy_done;
  end

  always_comb begin
    unique case (s_axi_araddr)
      OFS_STATUS: rd_word = status_reg;
      OFS_ENABLE: rd_word = enable_reg;
      default: rd_word = 32'h0;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      status_reg <= STATUS_RESET;
      enable_reg <= ENABLE_RESET;
      irq_reg <= 1'b0;
      mgmt_reg <= 1'b0;
      sof_reg <= 1'b0;
      ovc_reg <= OVC_RESET;
      ocr_prev_reg <= 1'b0;
      fn_msb_reg <= 1'b0;
      fn_pend_reg <= 1'b0;
    end else begin
      status_reg <= status_next;
      enable_reg <= enable_next;
      irq_reg <= irq_next;
      mgmt_reg <= mgmt_next;
      sof_reg <= sof_next;
      ovc_reg <= ovc_next;
      ocr_prev_reg <= ocr_prev_next;
      fn_msb_reg <= fn_msb_next;
      fn_pend_reg <= fn_pend_next;
    end
  end

  assign irq = irq_reg;
  assign system_management_interrupt = mgmt_reg;
  assign sof_token = sof_reg;
  // halt holds until software writes one to the error flag or reset clears it
  assign processing_halt = status_reg[B_ERR];
  // writeback logic must wait while this is high
  assign done_head_hold = status_reg[B_WDH];
  assign overrun_count = ovc_reg;

  sticky_hold_a: assert property (
    @(posedge aclk) disable iff (!aresetn)
    1'b1 |=> ((($past(status_reg) & ~$past(clr_vec)) & ~status_reg) == 32'h0)
  ) else $error("status flag dropped without a clear write");

  write_clear_a: assert property (
    @(posedge aclk) disable iff (!aresetn)
    (wr_valid && wr.addr == OFS_STATUS && wr.strb[0]
      && wr.data[B_SO] && !evt.overrun) |=> !status_reg[B_SO]
  ) else $error("overrun flag not cleared by write of one");

  irq_gate_a: assert property (
    @(posedge aclk) disable iff (!aresetn)
    (!enable_reg[B_GATE]
      || ~|(status_reg[B_OWN_CHG:0] & enable_reg[B_OWN_CHG:0]))
      |=> !irq
  ) else $error("interrupt raised without enabled flag and gate");

  irq_raise_a: assert property (
    @(posedge aclk) disable iff (!aresetn)
    (enable_reg[B_GATE] && status_reg[B_SO] && enable_reg[B_SO])
      |=> irq
  ) else $error("enabled overrun flag gave no interrupt");

  mgmt_raise_a: assert property (
    @(posedge aclk) disable iff (!aresetn)
    (status_reg[B_OWN_CHG] && enable_reg[B_OWN_CHG])
      |=> system_management_interrupt
  ) else $error("unmasked ownership change gave no management irq");

  own_set_a: assert property (
    @(posedge aclk) disable iff (!aresetn)
    ocr_rise |=> (status_reg[B_OWN_CHG] == MGMT_IRQ_PRESENT)
  ) else $error("ownership change flag wrong after request");

  fn_ovf_set_a: assert property (
    @(posedge aclk) disable iff (!aresetn)
    (evt.fn_copy_done && (fn_pend_reg || fn_toggle))
      |=> status_reg[B_FN_OVF]
  ) else $error("frame overflow flag not set after copy");

  resume_set_a: assert property (
    @(posedge aclk) disable iff (!aresetn)
    $rose(status_reg[B_RD]) |-> $past(res_rise && !bus_resume_state)
  ) else $error("resume flag set without device resume edge");

  frame_start_a: assert property (
    @(posedge aclk) disable iff (!aresetn)
    evt.frame_start |=> (status_reg[B_FRM_START] && sof_token)
  ) else $error("frame start flag or token missing");

  error_halt_a: assert property (
    @(posedge aclk) disable iff (!aresetn)
    evt.system_error |=> processing_halt
  ) else $error("system error did not halt processing");

  overrun_count_a: assert property (
    @(posedge aclk) disable iff (!aresetn)
    evt.overrun |=> (overrun_count == $past(overrun_count) + 2'h1)
  ) else $error("overrun count did not step");

  enable_sticky_a: assert property (
    @(posedge aclk) disable iff (!aresetn)
    1'b1 |=> ((~enable_reg & $past(enable_reg)) == 32'h0)
  ) else $error("enable bit fell");

  reserved_zero_a: assert property (
    @(posedge aclk) disable iff (!aresetn)
    ((status_reg & ~STATUS_MASK) == 32'h0)
      && ((enable_reg & ~ENABLE_MASK) == 32'h0)
  ) else $error("reserved bit became nonzero");

  hub_change_a: assert property (
    @(posedge aclk) disable iff (!aresetn)
    evt.root_hub_change |=> status_reg[B_HUB_CHG]
  ) else $error("root hub change flag not set");

  done_hold_a: assert property (
    @(posedge aclk) disable iff (!aresetn)
    evt.done_head_written |=> done_head_hold
  ) else $error("done head flag did not hold writeback");

  overrun_flag_a: assert property (
    @(posedge aclk) disable iff (!aresetn)
    evt.overrun |=> status_reg[B_SO]
  ) else $error("overrun flag not set");

  no_soft_set_a: assert property (
    @(posedge aclk) disable iff (!aresetn)
    (set_vec == 32'h0) |=> ((status_reg & ~$past(status_reg)) == 32'h0)
  ) else $error("status flag rose with no event");

  enable_set_a: assert property (
    @(posedge aclk) disable iff (!aresetn)
    (wr_valid && wr.addr == OFS_ENABLE && wr.strb[0] && wr.data[B_SO])
      |=> enable_reg[B_SO]
  ) else $error("enable bit not set by write of one");

  mgmt_gate_a: assert property (
    @(posedge aclk) disable iff (!aresetn)
    !(status_reg[B_OWN_CHG] && enable_reg[B_OWN_CHG])
      |=> !system_management_interrupt
  ) else $error("management interrupt without unmasked flag");

  sof_pulse_a: assert property (
    @(posedge aclk) disable iff (!aresetn)
    !evt.frame_start |=> !sof_token
  ) else $error("frame start token without frame start");

  fn_pending_a: assert property (
    @(posedge aclk) disable iff (!aresetn)
    (fn_toggle && !evt.fn_copy_done) |=> fn_pend_reg
  ) else $error("frame bit toggle lost before copy");

endmodule
